//--- i2c_ctrl_pkg.sv
// Shared constants for the serial bus control core and its peer
package i2c_ctrl_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] ADDR_CTRL_ONE = 12'h240;
  localparam logic [11:0] ADDR_DATA_BUF = 12'h241;
  localparam logic [11:0] ADDR_OWN_ADDR = 12'h242;
  localparam logic [11:0] ADDR_CTRL_TWO = 12'h243;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int COUNT_LSB = 5;
  localparam int ACK_BIT = 4;
  localparam int RATE_LSB = 0;
  localparam int MASTER_BIT = 7;
  localparam int TRANSMIT_BIT = 6;
  localparam int BUSY_BIT = 5;
  localparam int PIN_BIT = 4;
  localparam int MODE_LSB = 2;
  localparam int LOST_BIT = 3;
  localparam int AAS_BIT = 2;
  localparam int LRB_BIT = 0;
  localparam int RECOG_BIT = 0;
  localparam logic [1:0] MODE_I2C = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  // ************************************************************
  // Word and clock timing
  // ************************************************************
  localparam logic [3:0] WORD_BITS = 4'h8;
  localparam logic [3:0] WORD_CODE_FULL = 4'h0;
  localparam int LOW_BASE = 29;
  localparam int HIGH_BASE = 7;
  localparam int N_MIN = 4;
  localparam int SYS_PER_SBI = 2;
  localparam logic [2:0] RATE_MAX = 3'h6;
endpackage : i2c_ctrl_pkg

//--- i2c_link_if.sv
// Two-wire bus between the control core and its peer
`timescale 1ns/100ps
interface i2c_link_if;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic peer_scl_out;
  logic peer_scl_oe;
  logic peer_sda_out;
  logic peer_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-up: any enabled low driver wins
  assign scl = ~((dev_scl_oe & ~dev_scl_out) | (peer_scl_oe & ~peer_scl_out));
  assign sda = ~((dev_sda_oe & ~dev_sda_out) | (peer_sda_oe & ~peer_sda_out));
  modport device (input scl, input sda, output dev_scl_out, output dev_scl_oe,
    output dev_sda_out, output dev_sda_oe);
  modport peer (input scl, input sda, output peer_scl_out, output peer_scl_oe,
    output peer_sda_out, output peer_sda_oe);
endinterface : i2c_link_if

//--- i2c_bus_control_core.sv
// Serial bus control core: registers, clock generator and bit engine
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module i2c_bus_control_core (
  input wire logic clk_sys,
  input wire logic rst,
  i2c_link_if.device link,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic serial_bus_irq
);
  typedef enum logic [2:0] {GEN_IDLE, GEN_START, GEN_LOW, GEN_WAIT_HIGH, GEN_HIGH,
    GEN_STOP_LOW, GEN_STOP_WAIT, GEN_STOP_HIGH} gen_state_type;

  function automatic logic [11:0] sbi_period(input logic [2:0] rate, input logic [5:0] base);
    logic [2:0] code;
    logic [11:0] half;
    code = (rate > i2c_ctrl_pkg::RATE_MAX) ? i2c_ctrl_pkg::RATE_MAX : rate;
    half = (12'h1 << (4'({1'b0, code}) + 4'(i2c_ctrl_pkg::N_MIN - 1))) + 12'(base);
    return 12'(half * 12'(i2c_ctrl_pkg::SYS_PER_SBI));
  endfunction : sbi_period

  // ************************************************************
  // Pin synchronisers and bus events
  // ************************************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic scl_s;
  logic sda_s;
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [2:0] bit_count_select;
  logic ack_en;
  logic [2:0] scl_rate_select;
  logic [6:0] own_slave_addr;
  logic addr_recog_disable;
  logic master_select;
  logic transmit_select;
  logic bus_busy_flag;
  logic pending;
  logic arb_lost_flag;
  logic stop_pend;
  logic [1:0] interface_mode_select;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic tx_dir;
  logic lrb;
  logic [3:0] bit_idx;
  logic skip_fall;
  logic first_word;
  logic addressed;
  logic word_done;
  logic sda_low;
  logic scl_low;
  gen_state_type gen_state;
  logic [11:0] gen_cnt;

  logic wr_cr1;
  logic wr_dbr;
  logic wr_ar;
  logic wr_cr2;
  logic dbr_access;
  logic start_cmd;
  logic stop_cmd;
  logic mode_ok;
  assign wr_cr1 = reg_write & (reg_addr == i2c_ctrl_pkg::ADDR_CTRL_ONE);
  assign wr_dbr = reg_write & (reg_addr == i2c_ctrl_pkg::ADDR_DATA_BUF);
  assign wr_ar = reg_write & (reg_addr == i2c_ctrl_pkg::ADDR_OWN_ADDR);
  assign wr_cr2 = reg_write & (reg_addr == i2c_ctrl_pkg::ADDR_CTRL_TWO);
  assign dbr_access = wr_dbr | (reg_read & (reg_addr == i2c_ctrl_pkg::ADDR_DATA_BUF));
  assign mode_ok = (interface_mode_select == i2c_ctrl_pkg::MODE_I2C);
  assign start_cmd = wr_cr2 & ~bus_busy_flag & reg_wdata[i2c_ctrl_pkg::MASTER_BIT]
    & reg_wdata[i2c_ctrl_pkg::TRANSMIT_BIT] & reg_wdata[i2c_ctrl_pkg::BUSY_BIT]
    & reg_wdata[i2c_ctrl_pkg::PIN_BIT];
  assign stop_cmd = wr_cr2 & bus_busy_flag & reg_wdata[i2c_ctrl_pkg::MASTER_BIT]
    & reg_wdata[i2c_ctrl_pkg::TRANSMIT_BIT] & ~reg_wdata[i2c_ctrl_pkg::BUSY_BIT]
    & reg_wdata[i2c_ctrl_pkg::PIN_BIT];

  // ************************************************************
  // Word framing
  // ************************************************************
  logic [3:0] word_bits;
  logic engaged;
  logic last_data;
  logic in_ack;
  logic fall_ev;
  logic word_end;
  logic addr_match;
  logic slave_hit;
  logic arb_loss;
  assign word_bits = (bit_count_select == 3'h0) ? i2c_ctrl_pkg::WORD_BITS
    : {1'b0, bit_count_select};
  assign engaged = mode_ok & bus_busy_flag & (master_select | addressed | first_word);
  assign last_data = (bit_idx == word_bits - 4'h1);
  assign in_ack = ack_en & (bit_idx == word_bits);
  assign fall_ev = scl_fall & engaged & ~skip_fall;
  assign word_end = fall_ev & (ack_en ? in_ack : last_data);
  assign addr_match = ~addr_recog_disable
    & ((rx_shift[7:1] == own_slave_addr) | (rx_shift == 8'h00));
  assign slave_hit = fall_ev & first_word & last_data & ~master_select
    & (addr_recog_disable | addr_match);
  // Released data bit read back low while we send: another master won
  assign arb_loss = scl_rise & master_select & transmit_select & ~in_ack & ~sda_low
    & ~sda_s & ~skip_fall & bus_busy_flag;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bit_idx <= 4'h0;
      skip_fall <= 1'b0;
      first_word <= 1'b0;
      addressed <= 1'b0;
      word_done <= 1'b0;
    end
    else
    begin
      word_done <= 1'b0;
      if (start_det)
      begin
        // The start's own falling clock edge is not a data bit
        bit_idx <= 4'h0;
        skip_fall <= 1'b1;
        first_word <= 1'b1;
        addressed <= 1'b0;
      end
      else if (stop_det)
      begin
        first_word <= 1'b0;
        addressed <= 1'b0;
      end
      else if (scl_fall & skip_fall)
        skip_fall <= 1'b0;
      else if (fall_ev)
      begin
        bit_idx <= word_end ? 4'h0 : bit_idx + 4'h1;
        if (slave_hit)
          addressed <= 1'b1;
        if (word_end)
        begin
          first_word <= 1'b0;
          word_done <= master_select | addressed | slave_hit;
        end
      end
    end
  end

  // ************************************************************
  // Shift registers
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_shift <= 8'h00;
      tx_dir <= 1'b0;
      rx_shift <= 8'h00;
      lrb <= 1'b0;
    end
    else
    begin
      if (wr_dbr)
      begin
        tx_shift <= reg_wdata;
        tx_dir <= reg_wdata[0];
      end
      else if (fall_ev & ~in_ack)
        tx_shift <= {tx_shift[6:0], 1'b0};
      if (scl_rise & engaged & ~skip_fall)
      begin
        lrb <= sda_s;
        if (~in_ack)
          rx_shift <= {rx_shift[6:0], sda_s};
      end
    end
  end

  // ************************************************************
  // Control and status bits
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bit_count_select <= 3'h0;
      ack_en <= 1'b0;
      scl_rate_select <= 3'h0;
      own_slave_addr <= i2c_ctrl_pkg::OWN_ADDR_RESET[7:1];
      addr_recog_disable <= i2c_ctrl_pkg::OWN_ADDR_RESET[i2c_ctrl_pkg::RECOG_BIT];
      interface_mode_select <= i2c_ctrl_pkg::MODE_RESET;
    end
    else
    begin
      if (wr_cr1)
      begin
        ack_en <= reg_wdata[i2c_ctrl_pkg::ACK_BIT];
        scl_rate_select <= reg_wdata[i2c_ctrl_pkg::RATE_LSB +: 3];
      end
      if (start_det)
        bit_count_select <= 3'h0;
      else if (wr_cr1)
        bit_count_select <= reg_wdata[i2c_ctrl_pkg::COUNT_LSB +: 3];
      if (wr_ar)
      begin
        own_slave_addr <= reg_wdata[7:1];
        addr_recog_disable <= reg_wdata[i2c_ctrl_pkg::RECOG_BIT];
      end
      if (wr_cr2)
        interface_mode_select <= reg_wdata[i2c_ctrl_pkg::MODE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      master_select <= 1'b0;
      transmit_select <= 1'b0;
      bus_busy_flag <= 1'b0;
      pending <= 1'b1;
      arb_lost_flag <= 1'b0;
      stop_pend <= 1'b0;
    end
    else
    begin
      if (start_det)
        bus_busy_flag <= 1'b1;
      else if (stop_det)
        bus_busy_flag <= 1'b0;
      if (stop_det | arb_loss)
      begin
        master_select <= 1'b0;
        transmit_select <= 1'b0;
      end
      else
      begin
        if (wr_cr2)
        begin
          master_select <= reg_wdata[i2c_ctrl_pkg::MASTER_BIT];
          transmit_select <= reg_wdata[i2c_ctrl_pkg::TRANSMIT_BIT];
        end
        else if (slave_hit & ~addr_recog_disable)
          transmit_select <= rx_shift[0];
        else if (word_end & first_word & master_select & ack_en & ~lrb)
          transmit_select <= ~tx_dir;
      end
      // Hardware clearing wins, so no word end is missed by software
      if (word_done)
        pending <= 1'b0;
      else if (dbr_access | (wr_cr2 & reg_wdata[i2c_ctrl_pkg::PIN_BIT]))
        pending <= 1'b1;
      if (arb_loss)
        arb_lost_flag <= 1'b1;
      else if (dbr_access | wr_cr2)
        arb_lost_flag <= 1'b0;
      if (stop_cmd)
        stop_pend <= 1'b1;
      else if (stop_det | arb_loss)
        stop_pend <= 1'b0;
    end
  end

  // ************************************************************
  // Master clock generator
  // ************************************************************
  logic [11:0] low_cycles;
  logic [11:0] high_cycles;
  assign low_cycles = sbi_period(scl_rate_select, 6'(i2c_ctrl_pkg::LOW_BASE));
  assign high_cycles = sbi_period(scl_rate_select, 6'(i2c_ctrl_pkg::HIGH_BASE));

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      gen_state <= GEN_IDLE;
      gen_cnt <= 12'h000;
    end
    else
    begin
      gen_cnt <= gen_cnt + 12'h001;
      case (gen_state)
        GEN_IDLE:
        begin
          gen_cnt <= 12'h000;
          if (start_cmd & mode_ok)
            gen_state <= GEN_START;
        end
        GEN_START:
          if (gen_cnt >= high_cycles - 12'h001)
          begin
            gen_state <= GEN_LOW;
            gen_cnt <= 12'h000;
          end
        GEN_LOW:
          if (~master_select | ~mode_ok)
            gen_state <= GEN_IDLE;
          else if (~pending)
            gen_cnt <= 12'h000;
          else if (stop_pend)
          begin
            gen_state <= GEN_STOP_LOW;
            gen_cnt <= 12'h000;
          end
          else if (gen_cnt >= low_cycles - 12'h001)
            gen_state <= GEN_WAIT_HIGH;
        GEN_WAIT_HIGH:
          if (~master_select)
            gen_state <= GEN_IDLE;
          else if (scl_s)
          begin
            gen_state <= GEN_HIGH;
            gen_cnt <= 12'h000;
          end
        GEN_HIGH:
          if (~master_select)
            gen_state <= GEN_IDLE;
          else if (~scl_s | (gen_cnt >= high_cycles - 12'h001))
          begin
            gen_state <= GEN_LOW;
            gen_cnt <= 12'h000;
          end
        GEN_STOP_LOW:
          if (gen_cnt >= low_cycles - 12'h001)
            gen_state <= GEN_STOP_WAIT;
        GEN_STOP_WAIT:
          if (scl_s)
          begin
            gen_state <= GEN_STOP_HIGH;
            gen_cnt <= 12'h000;
          end
        GEN_STOP_HIGH:
          if (gen_cnt >= high_cycles - 12'h001)
            gen_state <= GEN_IDLE;
        default:
          gen_state <= GEN_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  logic next_sda_low;
  logic next_scl_low;
  logic gen_sda_low;
  logic data_sda_low;
  assign gen_sda_low = (gen_state == GEN_START) | (gen_state == GEN_STOP_LOW)
    | (gen_state == GEN_STOP_WAIT) | (gen_state == GEN_STOP_HIGH);
  // Slave acks its own address even when it will transmit next
  assign data_sda_low = (master_select | addressed) & bus_busy_flag & ~stop_pend
    & ~skip_fall & (in_ack ? (~transmit_select | (first_word & ~master_select))
    : (transmit_select & ~tx_shift[7]));
  assign next_sda_low = mode_ok & (gen_sda_low | data_sda_low);
  assign next_scl_low = mode_ok & ((gen_state == GEN_LOW) | (gen_state == GEN_STOP_LOW)
    | (~master_select & addressed & ~pending & ~scl_s));

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sda_low <= 1'b0;
      scl_low <= 1'b0;
      serial_bus_irq <= 1'b0;
    end
    else
    begin
      sda_low <= next_sda_low;
      scl_low <= next_scl_low;
      serial_bus_irq <= word_done;
    end
  end
  assign link.dev_scl_out = 1'b0;
  assign link.dev_sda_out = 1'b0;
  assign link.dev_scl_oe = scl_low;
  assign link.dev_sda_oe = sda_low;

  // ************************************************************
  // Register read port
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_read)
      case (reg_addr)
        i2c_ctrl_pkg::ADDR_CTRL_ONE:
          reg_rdata <= {bit_count_select, ack_en, 1'b0, scl_rate_select};
        i2c_ctrl_pkg::ADDR_DATA_BUF:
          reg_rdata <= rx_shift;
        i2c_ctrl_pkg::ADDR_OWN_ADDR:
          reg_rdata <= {own_slave_addr, addr_recog_disable};
        i2c_ctrl_pkg::ADDR_CTRL_TWO:
          reg_rdata <= {master_select, transmit_select, bus_busy_flag, pending,
            arb_lost_flag, addressed, 1'b0, lrb};
        default:
          reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end
endmodule : i2c_bus_control_core

//--- i2c_peer_slave.sv
// Far end of the two-wire bus: a plain addressable slave
`timescale 1ns/100ps
module i2c_peer_slave #(
  // Arbitrary neutral bus address
  parameter logic [6:0] PEER_ADDR = 7'h50
) (
  input wire logic clk_sys,
  input wire logic rst,
  i2c_link_if.peer link,
  input wire logic [7:0] peer_tx_byte,
  output logic [7:0] peer_rx_byte,
  output logic peer_rx_valid,
  output logic peer_selected
);
  typedef enum logic [1:0] {PEER_IDLE, PEER_ADDR_PH, PEER_WRITE, PEER_READ} peer_state_type;

  // ************************************************************
  // Pin synchronisers and bus events
  // ************************************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic scl_s;
  logic sda_s;
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ************************************************************
  // Byte engine, always nine clocks a word
  // ************************************************************
  peer_state_type state;
  logic [3:0] bit_idx;
  logic skip_fall;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic ack_drive;
  logic sda_low;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= PEER_IDLE;
      bit_idx <= 4'h0;
      skip_fall <= 1'b0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      ack_drive <= 1'b0;
      peer_rx_byte <= 8'h00;
      peer_rx_valid <= 1'b0;
    end
    else
    begin
      peer_rx_valid <= 1'b0;
      if (start_det)
      begin
        state <= PEER_ADDR_PH;
        bit_idx <= 4'h0;
        skip_fall <= 1'b1;
        ack_drive <= 1'b0;
      end
      else if (stop_det)
      begin
        state <= PEER_IDLE;
        ack_drive <= 1'b0;
      end
      else if (state != PEER_IDLE)
      begin
        if (scl_rise & ~skip_fall)
        begin
          if (bit_idx < i2c_ctrl_pkg::WORD_BITS)
            rx_shift <= {rx_shift[6:0], sda_s};
          else if ((state == PEER_READ) & sda_s)
            state <= PEER_IDLE; // Master did not ack: end of read
        end
        if (scl_fall & skip_fall)
          skip_fall <= 1'b0;
        else if (scl_fall)
        begin
          if (bit_idx == i2c_ctrl_pkg::WORD_BITS - 4'h1)
          begin
            bit_idx <= i2c_ctrl_pkg::WORD_BITS;
            if (state == PEER_ADDR_PH)
            begin
              ack_drive <= (rx_shift[7:1] == PEER_ADDR);
              state <= (rx_shift[7:1] != PEER_ADDR) ? PEER_IDLE
                : (rx_shift[0] ? PEER_READ : PEER_WRITE);
            end
            else if (state == PEER_WRITE)
            begin
              ack_drive <= 1'b1;
              peer_rx_byte <= rx_shift;
              peer_rx_valid <= 1'b1;
            end
          end
          else if (bit_idx == i2c_ctrl_pkg::WORD_BITS)
          begin
            // End of the acknowledge slot: drop our ack and load the next byte to send
            bit_idx <= 4'h0;
            ack_drive <= 1'b0;
            tx_shift <= peer_tx_byte;
          end
          else
          begin
            bit_idx <= bit_idx + 4'h1;
            tx_shift <= {tx_shift[6:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sda_low <= 1'b0;
    else
      sda_low <= ack_drive | ((state == PEER_READ) & ~skip_fall
        & (bit_idx < i2c_ctrl_pkg::WORD_BITS) & ~tx_shift[7]);
  end
  assign peer_selected = (state == PEER_WRITE) | (state == PEER_READ);
  assign link.peer_sda_oe = sda_low;
  assign link.peer_sda_out = 1'b0;
  assign link.peer_scl_oe = 1'b0;
  assign link.peer_scl_out = 1'b0;
endmodule : i2c_peer_slave

//--- i2c_link_assertions.sv
// Checker of the two-wire link between the core and its peer
`timescale 1ns/100ps
module i2c_link_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic peer_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ************************************************************
  // Line timing and data drive overlap
  // ************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_start_hold: assert property ($fell(sda) && scl |-> scl[*8])
    else $error("start held too short");
  chk_start_clock: assert property ($fell(sda) && scl |-> ##[20:40] !scl)
    else $error("no clock after start");
  chk_low_min: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low too short");
  chk_high_min: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high too short");
  // A stop ends the last high period, so a data rise also closes it
  chk_high_max: assert property ($rose(scl) |-> ##[20:40] (!scl || $rose(sda)))
    else $error("clock high too long");
  chk_ack_release: assert property (peer_sda_oe && scl |-> !dev_sda_oe)
    else $error("both ends drive data");
  chk_stop_free: assert property ($rose(sda) && scl |=> sda[*8])
    else $error("data line busy after stop");
  chk_bit_hold: assert property ($rose(peer_sda_oe) |-> peer_sda_oe[*8])
    else $error("peer bit too short");
endmodule : i2c_link_assertions

//--- i2c_bus_control_core_tb.sv
// Testbench joining the control core to a bus slave
`timescale 1ns/100ps
module i2c_bus_control_core_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic serial_bus_irq;
  logic [7:0] peer_rx_byte;
  logic peer_selected;
  logic peer_rx_valid;
  logic [7:0] rx_pulses = 8'h00;
  int fails = 0;
  int tests_run = 0;
  i2c_link_if link ();
  i2c_bus_control_core i2c_bus_control_core_i (.clk_sys(clk_sys), .rst(rst), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .serial_bus_irq(serial_bus_irq));
  i2c_peer_slave i2c_peer_slave_i (.clk_sys(clk_sys), .rst(rst), .link(link),
    .peer_tx_byte(8'h96), .peer_rx_byte(peer_rx_byte), .peer_rx_valid(peer_rx_valid),
    .peer_selected(peer_selected));
  i2c_link_assertions i2c_link_assertions_i (.clk_sys(clk_sys), .rst(rst),
    .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe),
    .peer_sda_oe(link.peer_sda_oe), .scl(link.scl), .sda(link.sda));
  // ************************************************************
  // Bus cycles and checks
  // ************************************************************
  initial forever #20 clk_sys = ~clk_sys;
  // Count written bytes the peer reports, one pulse each
  always @(posedge clk_sys)
    if (peer_rx_valid === 1'b1)
      rx_pulses <= rx_pulses + 8'h01;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Spare edge after each strobe so no signal is driven twice at once
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk(reg_rdata & m, e);
    @(posedge clk_sys);
  endtask : rd
  task automatic wait_irq;
    int n = 0;
    while (serial_bus_irq !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, n < 3000}, 8'h01);
    @(posedge clk_sys);
  endtask : wait_irq
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs;
    rd(12'h242, 8'hff, 8'h00);
    rd(12'h243, 8'hf0, 8'h10);
    wr(12'h242, 8'ha5);
    rd(12'h242, 8'hff, 8'ha5);
    rd(12'h250, 8'hff, 8'h00);
    wr(12'h243, 8'h00);
    rd(12'h243, 8'hf0, 8'h10);
  endtask : t_regs
  task automatic t_write;
    wr(12'h240, 8'h90);
    wr(12'h243, 8'h08);
    wr(12'h241, 8'ha0);
    wr(12'h243, 8'hf8);
    wait_irq();
    chk({7'h00, peer_selected}, 8'h01);
    rd(12'h240, 8'hff, 8'h10);
    rd(12'h243, 8'hf0, 8'he0);
    wr(12'h241, 8'h3c);
    wait_irq();
    chk(peer_rx_byte, 8'h3c);
    chk(rx_pulses, 8'h01);
    wr(12'h243, 8'hd8);
    // One low and one high period, plus sampling delay
    repeat (200) @(posedge clk_sys);
    rd(12'h243, 8'hf0, 8'h10);
  endtask : t_write
  task automatic t_read;
    wr(12'h241, 8'ha1);
    wr(12'h243, 8'hf8);
    wait_irq();
    rd(12'h243, 8'hf0, 8'ha0);
    rd(12'h241, 8'hff, 8'ha1);
    wait_irq();
    rd(12'h241, 8'hff, 8'h96);
  endtask : t_read
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_write();
    t_read();
    // Reset mid-transfer: the link must come back free
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(12'h243, 8'hf0, 8'h10);
    summarize();
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule : i2c_bus_control_core_tb
